// ---- hw/bkb_pkg.sv ----
// Package: register map, field positions and bus-cycle types for the break unit
package bkb_pkg;
  // Register word indices (byte address = 4 * index)
  localparam logic [3:0] IDX_ADDR_A_HI  = 4'h0;
  localparam logic [3:0] IDX_ADDR_A_LO  = 4'h1;
  localparam logic [3:0] IDX_AMSK_A_HI  = 4'h2;
  localparam logic [3:0] IDX_AMSK_A_LO  = 4'h3;
  localparam logic [3:0] IDX_CYC_A      = 4'h4;
  localparam logic [3:0] IDX_ADDR_B_HI  = 4'h5;
  localparam logic [3:0] IDX_ADDR_B_LO  = 4'h6;
  localparam logic [3:0] IDX_AMSK_B_HI  = 4'h7;
  localparam logic [3:0] IDX_AMSK_B_LO  = 4'h8;
  localparam logic [3:0] IDX_CYC_B      = 4'h9;
  localparam logic [3:0] IDX_DATA_B_HI  = 4'ha;
  localparam logic [3:0] IDX_DATA_B_LO  = 4'hb;
  localparam logic [3:0] IDX_DMSK_B_HI  = 4'hc;
  localparam logic [3:0] IDX_DMSK_B_LO  = 4'hd;
  localparam logic [3:0] IDX_CTRL       = 4'he;
  localparam int         NUM_REGS       = 15;

  localparam logic [15:0] RST_VAL       = 16'h0000;
  // Writable bits of the break control register
  localparam logic [15:0] CTRL_WMASK    = 16'hf4dc;

  // Break control bit positions
  localparam int CTL_CORE_A   = 15;
  localparam int CTL_PERI_A   = 14;
  localparam int CTL_EXT_EN   = 13;
  localparam int CTL_LAYOUT   = 12;
  localparam int CTL_TIME_A   = 10;
  localparam int CTL_CORE_B   = 7;
  localparam int CTL_PERI_B   = 6;
  localparam int CTL_SEQ      = 4;
  localparam int CTL_DATA_EN  = 3;
  localparam int CTL_TIME_B   = 2;

  // Cycle-select field positions (low bit of each 2-bit pair)
  localparam int CS_MASTER = 6;
  localparam int CS_FETCH  = 4;
  localparam int CS_DIR    = 2;
  localparam int CS_SIZE   = 0;

  // Operand size codes
  localparam logic [1:0] SZ_ANY  = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_LONG = 2'h3;

  // Bus master codes
  typedef enum logic [1:0] {
    MST_CORE = 2'b00,
    MST_DMA  = 2'b01,
    MST_EXT  = 2'b10
  } bkb_master_e;

  // One observed bus cycle
  typedef struct packed {
    logic        valid;   // Cycle completes this clock
    bkb_master_e master;  // Who drives it
    logic        fetch;   // Instruction fetch, else data
    logic        write;   // Write, else read
    logic [1:0]  size;    // Byte, word or long access size
    logic [31:0] addr;    // Address bus
    logic [31:0] data;    // Data bus
  } bkb_cycle_s;
endpackage : bkb_pkg

// ---- hw/bkb_break_unit.sv ----
// Breakpoint unit: two-channel bus-cycle comparator with Avalon-MM registers
// Behaviour
// - Size is word for fetch, else access
// - Size code three matches longword only
// - Channel B data compare, two halves, reset zero
// - Data mask bit one excludes that bit
// - External master cycles never compare data
// - Channel A core flag bit 15, sticky
// - Channel A peripheral flag bit 14
// - Channel B flags bits 7 and 6
// - Bit 13 enables external master monitoring
// - External monitoring works in every config
// - Bit 12 selects comparator layout
// - Bit 10 channel A before/after fetch break
// - Bit 4 sequential A then B
// - Bit 3 gates channel B data compare
// - Reserved control bits read zero
// - Reset clears break control register
// - Channel B address/cycle layout equals A
// - Size codes any, byte, word, long
// - Data enable zero excludes, one includes
// - Bit 2 channel B before/after fetch break
// - Match raises break request and sets flags; in sequence mode an A match only arms for B
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
module bkb_break_unit (
  input  wire logic              sys_clk,         // 25 MHz system clock
  input  wire logic              rst_n,           // Sync reset, active low
  input  wire logic [5:0]        avs_address,     // Byte address
  input  wire logic              avs_read,        // Read request
  input  wire logic              avs_write,       // Write request
  input  wire logic [31:0]       avs_writedata,   // Write data
  input  wire logic [3:0]        avs_byteenable,  // Byte lanes
  output logic      [31:0]       avs_readdata,    // Read data
  output logic                   avs_waitrequest, // Stall
  input  wire bkb_pkg::bkb_cycle_s busCycle,      // Observed bus cycle
  output logic                   breakReq,        // Break request pulse
  output logic                   breakAfterExec,  // Request is post-exec
  output logic                   layoutNative     // Extended layout on
);
  logic [15:0] regs_q [bkb_pkg::NUM_REGS];
  logic [15:0] regs_d [bkb_pkg::NUM_REGS];
  logic        seqArmed_q;
  logic        ack_q;
  logic        breakReq_q;
  logic        afterExec_q;
  logic [31:0] readData_q;
  logic [3:0]  idx;
  logic        mapped;
  logic        hitA;
  logic        hitB;
  logic        peripheral;
  logic        extOk;
  logic        fireB;
  logic [15:0] ctrl;
  logic        waitReq_q;
  logic [3:0]  flagBits;
  logic        ctrlWrite;

  // Size as seen by the comparator; fetches count as word
  function automatic logic [1:0] effSize(input bkb_pkg::bkb_cycle_s c);
    effSize = c.fetch ? bkb_pkg::SZ_WORD : c.size;
  endfunction : effSize

  // Pair-select test: bit0 = first choice, bit1 = second choice
  function automatic logic pairOk(input logic [1:0] sel, input logic second);
    pairOk = second ? sel[1] : sel[0];
  endfunction : pairOk

  // Address compare honouring access size alignment and mask
  function automatic logic addrOk(input logic [31:0] ref_v,
                                  input logic [31:0] msk,
                                  input logic [31:0] a,
                                  input logic [1:0]  sz);
    logic [31:0] ign;
    ign = msk;
    if (sz == bkb_pkg::SZ_LONG)
      ign[1:0] = 2'h3;
    else if (sz == bkb_pkg::SZ_WORD)
      ign[0] = 1'b1;
    addrOk = ((ref_v ^ a) & ~ign) == 32'h0000_0000;
  endfunction : addrOk

  // Whole-channel match; same field layout for both channels
  function automatic logic chanHit(input logic [31:0] ref_v,
                                   input logic [31:0] msk,
                                   input logic [7:0]  cs,
                                   input bkb_pkg::bkb_cycle_s c,
                                   input logic periph,
                                   input logic extAllowed);
    logic [1:0] szSel;
    logic       szOk;
    logic       ext;
    ext   = (c.master == bkb_pkg::MST_EXT);
    szSel = cs[bkb_pkg::CS_SIZE +: 2];
    unique case (szSel)
      bkb_pkg::SZ_ANY:  szOk = 1'b1;
      bkb_pkg::SZ_BYTE: szOk = effSize(c) == bkb_pkg::SZ_BYTE;
      bkb_pkg::SZ_WORD: szOk = effSize(c) == bkb_pkg::SZ_WORD;
      bkb_pkg::SZ_LONG: szOk = effSize(c) == bkb_pkg::SZ_LONG;
    endcase
    if (ext)
      szOk = 1'b1; // External cycles carry no size
    chanHit = c.valid && (!ext || extAllowed)
      && pairOk(cs[bkb_pkg::CS_MASTER +: 2], periph)
      && pairOk(cs[bkb_pkg::CS_FETCH +: 2], !c.fetch || ext)
      && pairOk(cs[bkb_pkg::CS_DIR +: 2], c.write)
      && szOk
      && addrOk(ref_v, msk, c.addr, ext ? bkb_pkg::SZ_BYTE : effSize(c));
  endfunction : chanHit

  assign ctrl = regs_q[bkb_pkg::IDX_CTRL];
  assign idx = avs_address[5:2];
  assign mapped = (idx < 4'(bkb_pkg::NUM_REGS));
  assign peripheral = (busCycle.master != bkb_pkg::MST_CORE);
  // Monitoring does not depend on master/slave strap
  assign extOk = ctrl[bkb_pkg::CTL_EXT_EN];

  // Channel comparisons
  always_comb
  begin
    logic [31:0] dmask;
    logic        dataOk;
    dmask = {regs_q[bkb_pkg::IDX_DMSK_B_HI], regs_q[bkb_pkg::IDX_DMSK_B_LO]};
    dataOk = 1'b0;
    hitA = chanHit({regs_q[bkb_pkg::IDX_ADDR_A_HI],
                    regs_q[bkb_pkg::IDX_ADDR_A_LO]},
                   {regs_q[bkb_pkg::IDX_AMSK_A_HI],
                    regs_q[bkb_pkg::IDX_AMSK_A_LO]},
                   regs_q[bkb_pkg::IDX_CYC_A][7:0], busCycle,
                   peripheral, extOk);
    // Byte and word sizes compare only the low half
    if (effSize(busCycle) != bkb_pkg::SZ_LONG)
      dmask[31:16] = 16'hffff;
    dataOk = ((busCycle.data ^ {regs_q[bkb_pkg::IDX_DATA_B_HI],
               regs_q[bkb_pkg::IDX_DATA_B_LO]}) & ~dmask) == 32'h0000_0000;
    if (!ctrl[bkb_pkg::CTL_DATA_EN] || busCycle.fetch)
      dataOk = 1'b1;
    if (ctrl[bkb_pkg::CTL_DATA_EN] && busCycle.master == bkb_pkg::MST_EXT)
      dataOk = 1'b0;
    hitB = dataOk && chanHit({regs_q[bkb_pkg::IDX_ADDR_B_HI],
                              regs_q[bkb_pkg::IDX_ADDR_B_LO]},
                             {regs_q[bkb_pkg::IDX_AMSK_B_HI],
                              regs_q[bkb_pkg::IDX_AMSK_B_LO]},
                             regs_q[bkb_pkg::IDX_CYC_B][7:0], busCycle,
                             peripheral, extOk);
  end

  // In sequence mode B counts only after an earlier A
  assign fireB = hitB && (!ctrl[bkb_pkg::CTL_SEQ] || seqArmed_q);

  // Register next values: bus write, then sticky flags win
  always_comb
  begin
    for (int i = 0; i < bkb_pkg::NUM_REGS; i++)
      regs_d[i] = regs_q[i];
    if (avs_write && ack_q && mapped)
    begin
      if (avs_byteenable[0])
        regs_d[idx][7:0] = avs_writedata[7:0];
      if (avs_byteenable[1])
        regs_d[idx][15:8] = avs_writedata[15:8];
    end
    // Reserved bits stay zero
    regs_d[bkb_pkg::IDX_CTRL] = regs_d[bkb_pkg::IDX_CTRL]
                               & bkb_pkg::CTRL_WMASK;
    regs_d[bkb_pkg::IDX_CYC_A][15:8] = 8'h00;
    regs_d[bkb_pkg::IDX_CYC_B][15:8] = 8'h00;
    // Set beats a same-cycle clear; hardware never clears
    if (hitA && !ctrl[bkb_pkg::CTL_SEQ])
    begin
      if (peripheral)
        regs_d[bkb_pkg::IDX_CTRL][bkb_pkg::CTL_PERI_A] = 1'b1;
      else
        regs_d[bkb_pkg::IDX_CTRL][bkb_pkg::CTL_CORE_A] = 1'b1;
    end
    if (fireB)
    begin
      if (peripheral)
        regs_d[bkb_pkg::IDX_CTRL][bkb_pkg::CTL_PERI_B] = 1'b1;
      else
        regs_d[bkb_pkg::IDX_CTRL][bkb_pkg::CTL_CORE_B] = 1'b1;
    end
  end

  // Register storage
  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < bkb_pkg::NUM_REGS; i++)
      regs_q[i] <= rst_n ? regs_d[i] : bkb_pkg::RST_VAL;
  end

  // Sequence arm: A seen, waiting for B
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || !ctrl[bkb_pkg::CTL_SEQ])
      seqArmed_q <= 1'b0;
    else if (fireB)
      seqArmed_q <= 1'b0;
    else if (hitA)
      seqArmed_q <= 1'b1;
  end

  // Break request and its timing
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      breakReq_q  <= 1'b0;
      afterExec_q <= 1'b0;
    end
    else
    begin
      breakReq_q <= fireB || (hitA && !ctrl[bkb_pkg::CTL_SEQ]);
      if (fireB)
        afterExec_q <= busCycle.fetch && ctrl[bkb_pkg::CTL_TIME_B];
      else
        afterExec_q <= busCycle.fetch && ctrl[bkb_pkg::CTL_TIME_A];
    end
  end

  // Avalon slave: one wait state, answer on second edge
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ack_q     <= 1'b0;
      waitReq_q <= 1'b1;
    end
    else
    begin
      ack_q     <= (avs_read || avs_write) && !ack_q;
      // Stall pin has its own flop so no gate sits on the output
      waitReq_q <= !((avs_read || avs_write) && !ack_q);
    end
  end

  // Read data; unmapped reads return zero
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      readData_q <= 32'h0000_0000;
    else if (avs_read && !ack_q)
      readData_q <= mapped ? {16'h0000, regs_q[idx]} : 32'h0000_0000;
  end

  assign avs_readdata    = readData_q;
  assign avs_waitrequest = waitReq_q;
  assign breakReq        = breakReq_q;
  assign breakAfterExec  = afterExec_q;
  assign layoutNative    = ctrl[bkb_pkg::CTL_LAYOUT];

  // Match flags and the bus write that alone may clear them
  assign flagBits  = {ctrl[bkb_pkg::CTL_CORE_A], ctrl[bkb_pkg::CTL_PERI_A],
                      ctrl[bkb_pkg::CTL_CORE_B], ctrl[bkb_pkg::CTL_PERI_B]};
  assign ctrlWrite = avs_write && ack_q && (idx == bkb_pkg::IDX_CTRL);

  // A reported match, which must raise the request one clock later
  sequence s_fire;
    fireB || (hitA && !ctrl[bkb_pkg::CTL_SEQ]);
  endsequence

  // Checks
  sequence s_armed;
    ctrl[bkb_pkg::CTL_SEQ] && hitA && !fireB;
  endsequence

  a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(ctrl[bkb_pkg::CTL_CORE_A]) |-> $past(hitA) || $past(avs_write))
    else $error("core flag A rose without cause");
  a_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hitA && peripheral && !ctrl[bkb_pkg::CTL_SEQ]
      |=> ctrl[bkb_pkg::CTL_PERI_A])
    else $error("peripheral flag A not set");
  a_flagb_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fireB && !peripheral |=> ctrl[bkb_pkg::CTL_CORE_B])
    else $error("core flag B not set");
  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ctrl & ~bkb_pkg::CTRL_WMASK) == 16'h0000)
    else $error("reserved control bit set");
  a_ext_nodata: assert property (@(posedge sys_clk) disable iff (!rst_n)
    busCycle.master == bkb_pkg::MST_EXT && ctrl[bkb_pkg::CTL_DATA_EN]
      |-> !hitB)
    else $error("external cycle matched data");
  a_ext_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    busCycle.master == bkb_pkg::MST_EXT && !extOk |-> !hitA && !hitB)
    else $error("external cycle matched while disabled");
  a_seq_order: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_armed |=> seqArmed_q)
    else $error("sequence not armed after A");
  a_req_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
    breakReq |-> $past(hitA) || $past(hitB))
    else $error("break request without match");
  a_bus_answer: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("slave answer late");
  a_flags_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ($past(flagBits) & ~flagBits) != 4'h0 |-> $past(ctrlWrite))
    else $error("match flag cleared without a bus write");
  a_core_a_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hitA && !peripheral && !ctrl[bkb_pkg::CTL_SEQ]
      |=> ctrl[bkb_pkg::CTL_CORE_A])
    else $error("core flag A not set");
  a_perib_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fireB && peripheral |=> ctrl[bkb_pkg::CTL_PERI_B])
    else $error("peripheral flag B not set");
  a_req_on_hit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_fire |=> breakReq)
    else $error("break request missing after match");
  a_seq_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl[bkb_pkg::CTL_SEQ] && !fireB |=> !breakReq)
    else $error("request in sequence mode without B");
  a_timing_b: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fireB |=> breakAfterExec
      == ($past(busCycle.fetch) && $past(ctrl[bkb_pkg::CTL_TIME_B])))
    else $error("channel B break timing wrong");
  a_timing_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hitA && !fireB && !ctrl[bkb_pkg::CTL_SEQ] |=> breakAfterExec
      == ($past(busCycle.fetch) && $past(ctrl[bkb_pkg::CTL_TIME_A])))
    else $error("channel A break timing wrong");
  a_fetch_word: assert property (@(posedge sys_clk) disable iff (!rst_n)
    busCycle.fetch && busCycle.master != bkb_pkg::MST_EXT
      && regs_q[bkb_pkg::IDX_CYC_A][bkb_pkg::CS_SIZE +: 2]
         == bkb_pkg::SZ_LONG |-> !hitA)
    else $error("fetch matched a longword size select");
  a_data_miss: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl[bkb_pkg::CTL_DATA_EN] && !busCycle.fetch
      && ((busCycle.data[15:0] ^ regs_q[bkb_pkg::IDX_DATA_B_LO])
          & ~regs_q[bkb_pkg::IDX_DMSK_B_LO]) != 16'h0000
      |-> !hitB)
    else $error("channel B matched on a data miss");
  a_wait_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("slave answer longer than one cycle");
  a_wr_lands: assert property (@(posedge sys_clk) disable iff (!rst_n)
    avs_write && ack_q && idx == bkb_pkg::IDX_DATA_B_LO
      && avs_byteenable[1:0] == 2'h3
      |=> regs_q[bkb_pkg::IDX_DATA_B_LO] == $past(avs_writedata[15:0]))
    else $error("data compare write lost");
  a_reset_clear: assert property (@(posedge sys_clk)
    !rst_n |=> ctrl == 16'h0000 && !breakReq && avs_waitrequest)
    else $error("reset left state behind");
endmodule : bkb_break_unit

// ---- tb/bkb_bus_src.sv ----
// Bus-cycle source standing in for the core, DMA and external masters
`timescale 1ns/1ps
module bkb_bus_src (
  input  wire logic           sys_clk,  // System clock
  output bkb_pkg::bkb_cycle_s busCycle  // Cycle seen by the comparator
);
  initial busCycle = '0;

  // One completed cycle; the idle bus shows the inverse, never stale data
  task automatic issue(input logic [1:0] mst, input logic fch,
                       input logic wr, input logic [1:0] sz,
                       input logic [31:0] a, input logic [31:0] d);
    logic [70:0] cyc;
    cyc = {1'b1, mst, fch, wr, sz, a, d};
    @(posedge sys_clk);
    busCycle <= bkb_pkg::bkb_cycle_s'(cyc);
    @(posedge sys_clk);
    busCycle <= bkb_pkg::bkb_cycle_s'({1'b0, ~cyc[69:0]});
  endtask : issue
endmodule : bkb_bus_src

// ---- tb/testbench.sv ----
// Self-checking bench for the break control and channel B data logic
`timescale 1ns/1ps
module testbench;
  logic                sys_clk = 1'b0;
  logic                rst_n = 1'b0;
  logic [5:0]          avs_address = '0;
  logic                avs_read = 1'b0;
  logic                avs_write = 1'b0;
  logic [31:0]         avs_writedata = '0;
  logic [31:0]         avs_readdata;
  logic                avs_waitrequest;
  bkb_pkg::bkb_cycle_s busCycle;
  logic                breakReq;
  logic                breakAfterExec;
  logic                layoutNative;
  int                  fail_count = 0;
  int                  compares = 0;
  logic [31:0]         rd;
  logic [15:0]         v;

  // 25 MHz system clock
  always #20 sys_clk = ~sys_clk;

  bkb_break_unit i_bkb_break_unit (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h3),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .busCycle(busCycle), .breakReq(breakReq),
    .breakAfterExec(breakAfterExec), .layoutNative(layoutNative));

  bkb_bus_src i_bkb_bus_src (.sys_clk(sys_clk), .busCycle(busCycle));

  task automatic conclude();
    if (fail_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Request held until waitrequest samples low; bounded wait
  task automatic access(input logic wr, input logic [3:0] idx,
                        input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address   <= {idx, 2'b00};
    avs_read      <= ~wr;
    avs_write     <= wr;
    avs_writedata <= {16'h0000, wd};
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0)
    begin
      fail_count++;
      conclude();
    end
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : access

  task automatic wr(input logic [3:0] idx, input logic [15:0] wd);
    access(1'b1, idx, wd);
  endtask : wr

  task automatic rchk(input string name, input logic [3:0] idx,
                      input logic [15:0] exp);
    access(1'b0, idx, 16'h0000);
    check(name, rd, {16'h0000, exp});
  endtask : rchk

  // Cycle, then request and timing while the one-clock pulse stands
  task automatic cyc(input logic [1:0] m, input logic f, input logic w,
                     input logic [1:0] sz, input logic [31:0] a,
                     input logic [31:0] d, input logic [1:0] e);
    i_bkb_bus_src.issue(m, f, w, sz, a, d);
    #1;
    check("break", {30'h0, breakAfterExec & breakReq, breakReq}, {30'h0, e});
  endtask : cyc

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    conclude();
  end

  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 16; i++)
      rchk("reset", 4'(i), 16'h0000);
    for (int i = 0; i < 16; i++)
      wr(4'(i), 16'ha5c3 ^ 16'(i));
    for (int i = 0; i < 14; i++)
    begin
      v = 16'ha5c3 ^ 16'(i);
      // Cycle-select upper byte is reserved
      if (i == 4 || i == 9)
        v = v & 16'h00ff;
      rchk("regrw", 4'(i), v);
    end
    rchk("unmapped", 4'hf, 16'h0000);
    for (int i = 0; i < 14; i++)
      wr(4'(i), 16'h0000);
    wr(4'he, 16'hffff);
    rchk("ctrl", 4'he, 16'hf4dc);
    check("layout", {31'h0, layoutNative}, 32'h1);
    wr(4'he, 16'h0000);
    rchk("ctrl", 4'he, 16'h0000);
    check("layout", {31'h0, layoutNative}, 32'h0);
    // Channel A: core, DMA and external cycles at 0x1000
    wr(4'h1, 16'h1000);
    wr(4'h4, 16'h006c);
    cyc(2'b00, 1'b0, 1'b1, 2'h3, 32'h1004, 32'h0, 2'b00);
    cyc(2'b00, 1'b0, 1'b1, 2'h3, 32'h1000, 32'h0, 2'b01);
    rchk("flagA", 4'he, 16'h8000);
    wr(4'h4, 16'h00ac);
    cyc(2'b01, 1'b0, 1'b0, 2'h2, 32'h1000, 32'h0, 2'b01);
    cyc(2'b10, 1'b0, 1'b0, 2'h2, 32'h1000, 32'h0, 2'b00);
    rchk("flagP", 4'he, 16'hc000);
    wr(4'he, 16'h2000);
    cyc(2'b10, 1'b0, 1'b0, 2'h2, 32'h1000, 32'h0, 2'b01);
    rchk("flagE", 4'he, 16'h6000);
    // Channel B word data compare at 0x2000
    wr(4'h6, 16'h2000);
    wr(4'h9, 16'h006e);
    wr(4'hb, 16'hbeef);
    wr(4'he, 16'h0008);
    cyc(2'b00, 1'b0, 1'b1, 2'h2, 32'h2000, 32'hbeef, 2'b01);
    cyc(2'b00, 1'b0, 1'b1, 2'h2, 32'h2000, 32'hbeee, 2'b00);
    wr(4'hd, 16'h0001);
    cyc(2'b00, 1'b0, 1'b1, 2'h2, 32'h2000, 32'hbeee, 2'b01);
    rchk("flagB", 4'he, 16'h0088);
    wr(4'he, 16'h0000);
    cyc(2'b00, 1'b0, 1'b1, 2'h2, 32'h2000, 32'h1234, 2'b01);
    wr(4'h9, 16'h00ae);
    wr(4'he, 16'h2008);
    cyc(2'b10, 1'b0, 1'b1, 2'h2, 32'h2000, 32'hbeef, 2'b00);
    rchk("flagPB", 4'he, 16'h2008);
    wr(4'he, 16'h0000);
    // Every size code against every access size
    for (int s = 0; s < 4; s++)
    begin
      wr(4'h9, 16'h006c | 16'(s));
      for (int a = 1; a < 4; a++)
        cyc(2'b00, 1'b0, 1'b0, 2'(a), 32'h2000, 32'h0,
            {1'b0, s == 0 || s == a});
    end
    // Sequential: B alone, then A, then B
    wr(4'h4, 16'h006c);
    wr(4'h9, 16'h006c);
    wr(4'he, 16'h0010);
    cyc(2'b00, 1'b0, 1'b0, 2'h3, 32'h2000, 32'h0, 2'b00);
    cyc(2'b00, 1'b0, 1'b0, 2'h3, 32'h1000, 32'h0, 2'b00);
    cyc(2'b00, 1'b0, 1'b0, 2'h3, 32'h2000, 32'h0, 2'b01);
    rchk("seq", 4'he, 16'h0090);
    // Fetch breaks: before on A, then after execution on A and B
    wr(4'h4, 16'h0056);
    wr(4'h9, 16'h0056);
    wr(4'he, 16'h0000);
    cyc(2'b00, 1'b1, 1'b0, 2'h3, 32'h1000, 32'h0, 2'b01);
    wr(4'he, 16'h0400);
    cyc(2'b00, 1'b1, 1'b0, 2'h3, 32'h1000, 32'h0, 2'b11);
    wr(4'he, 16'h0004);
    cyc(2'b00, 1'b1, 1'b0, 2'h3, 32'h2000, 32'h0, 2'b11);
    // Fetches are word size, so a longword select never takes them
    wr(4'h4, 16'h0057);
    cyc(2'b00, 1'b1, 1'b0, 2'h3, 32'h1000, 32'h0, 2'b00);
    conclude();
  end
endmodule : testbench
